/* design/srdr_consts.svh */
// register offsets, field positions, reset values and timing counts for the slot/drive/restart bank
// assumes an 8-bit register port addressed by byte offset
`ifndef SRDR_CONSTS_SVH
`define SRDR_CONSTS_SVH
`define SRDR_OFF_CHAN7 8'h10
`define SRDR_OFF_DRIVE 8'h11
`define SRDR_OFF_RESTART 8'h12
`define SRDR_RST_CHAN7 8'h71
`define SRDR_RST_DRIVE 8'h2A
`define SRDR_SLOT_HI 7
`define SRDR_SLOT_LO 4
`define SRDR_EN_BIT 0
`define SRDR_AUDIO_HI 5
`define SRDR_AUDIO_LO 4
`define SRDR_MICB_HI 3
`define SRDR_MICB_LO 2
`define SRDR_MICA_HI 1
`define SRDR_MICA_LO 0
`define SRDR_FULL_BIT 1
`define SRDR_LOGIC_BIT 0
`define SRDR_PULSE_NS 200
`define SRDR_CLK_NS 50
`define SRDR_PULSE_CYC ((`SRDR_PULSE_NS + `SRDR_CLK_NS - 1) / `SRDR_CLK_NS)
`endif

/* design/srdr_pkg.sv */
// types shared by the slot/drive/restart register bank
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package srdr_pkg;
	typedef logic [7:0] srdr_byte_t;
	typedef logic [1:0] srdr_strength_t;
	typedef enum logic [1:0] {SRDR_RUN, SRDR_FULL, SRDR_LOGIC} srdr_state_t;
endpackage : srdr_pkg
`default_nettype wire

/* design/srdr_regs.sv */
// slot/drive/restart register bank: channel 7 routing, pad strengths, software restarts
// assumes a synchronous 8-bit register port on core_clk with one-cycle write/read strobes
`include "srdr_consts.svh"
`default_nettype none
module srdr_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// channel 7 routing
	output logic [3:0] chan7_slot_select,
	output logic chan7_output_enable,
	// pad strengths
	output logic [1:0] audio_out_pad_strength,
	output logic [1:0] mic_clock_b_pad_strength,
	output logic [1:0] mic_clock_a_pad_strength,
	// restart to the datapath
	output logic logic_restart,
	output logic restart_busy
);
	logic [7:0] chan7_slot_route;
	logic [7:0] pad_drive_strength;
	logic full_cmd;
	logic logic_cmd;
	logic regs_restart;
	logic [7:0] next_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// restart commands
	assign full_cmd = reg_write && reg_addr == `SRDR_OFF_RESTART
		&& reg_wdata[`SRDR_FULL_BIT];
	assign logic_cmd = reg_write && reg_addr == `SRDR_OFF_RESTART
		&& reg_wdata[`SRDR_LOGIC_BIT];

	srdr_restart_seq u_seq (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.full_cmd(full_cmd),
		.logic_cmd(logic_cmd),
		.regs_restart(regs_restart),
		.logic_restart(logic_restart),
		.busy(restart_busy)
	);

	////////////////////////////////////////////////////////////////////////////////
	// channel 7 routing register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			chan7_slot_route <= `SRDR_RST_CHAN7;
		end else if (regs_restart) begin
			chan7_slot_route <= `SRDR_RST_CHAN7;
		end else if (reg_write && reg_addr == `SRDR_OFF_CHAN7) begin
			chan7_slot_route <= reg_wdata & 8'hF1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pad drive strength register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pad_drive_strength <= `SRDR_RST_DRIVE;
		end else if (regs_restart) begin
			pad_drive_strength <= `SRDR_RST_DRIVE;
		end else if (reg_write && reg_addr == `SRDR_OFF_DRIVE) begin
			pad_drive_strength <= reg_wdata & 8'h3F;
		end
	end

	assign chan7_slot_select = chan7_slot_route[`SRDR_SLOT_HI:`SRDR_SLOT_LO];
	assign chan7_output_enable = chan7_slot_route[`SRDR_EN_BIT];
	assign audio_out_pad_strength = pad_drive_strength[`SRDR_AUDIO_HI:`SRDR_AUDIO_LO];
	assign mic_clock_b_pad_strength = pad_drive_strength[`SRDR_MICB_HI:`SRDR_MICB_LO];
	assign mic_clock_a_pad_strength = pad_drive_strength[`SRDR_MICA_HI:`SRDR_MICA_LO];

	////////////////////////////////////////////////////////////////////////////////
	// read data
	always_comb begin
		case (reg_addr)
			`SRDR_OFF_CHAN7: next_rdata = chan7_slot_route;
			`SRDR_OFF_DRIVE: next_rdata = pad_drive_strength;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// check helpers
	logic first_cycle;
	logic [2:0] pulse_len;
	logic chan7_wr;
	logic drive_wr;

	assign chan7_wr = reg_write && reg_addr == `SRDR_OFF_CHAN7;
	assign drive_wr = reg_write && reg_addr == `SRDR_OFF_DRIVE;

	// high only at the first edge after reset is released
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			first_cycle <= 1'b1;
		end else begin
			first_cycle <= 1'b0;
		end
	end

	// counts the edges the restart pulse has stood, saturating
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pulse_len <= 3'h0;
		end else if (!logic_restart) begin
			pulse_len <= 3'h0;
		end else if (pulse_len != 3'h7) begin
			pulse_len <= pulse_len + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence full_req_s;
		reg_write && reg_addr == `SRDR_OFF_RESTART
		&& reg_wdata[`SRDR_FULL_BIT] && !restart_busy;
	endsequence

	sequence pulse_s;
		logic_restart [*4];
	endsequence

	sequence logic_req_s;
		logic_cmd && !full_cmd && !restart_busy;
	endsequence

	// register fields
	chan7_reserved_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		chan7_slot_route[3:1] == 3'h0)
		else $error("channel 7 reserved bits set");
	drive_reserved_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		pad_drive_strength[7:6] == 2'h0)
		else $error("drive reserved bits set");
	slot_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(chan7_wr && !regs_restart) |=> chan7_slot_select == $past(reg_wdata[7:4]))
		else $error("slot select not written");
	enable_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(chan7_wr && !regs_restart) |=> chan7_output_enable == $past(reg_wdata[0]))
		else $error("output enable not written");
	audio_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(drive_wr && !regs_restart) |=> audio_out_pad_strength == $past(reg_wdata[5:4]))
		else $error("audio strength not written");
	micb_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(drive_wr && !regs_restart) |=> mic_clock_b_pad_strength == $past(reg_wdata[3:2]))
		else $error("mic b strength not written");
	mica_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(drive_wr && !regs_restart) |=> mic_clock_a_pad_strength == $past(reg_wdata[1:0]))
		else $error("mic a strength not written");
	chan7_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!chan7_wr && !regs_restart) |=> $stable(chan7_slot_route))
		else $error("channel 7 register changed without a write");
	drive_hold_a: assert property (@(posedge core_clk)
		disable iff (!arst_n)
		(!drive_wr && !regs_restart) |=> $stable(pad_drive_strength))
		else $error("drive register changed without a write");

	// reset and restart
	chan7_reset_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		first_cycle |-> (chan7_slot_route == `SRDR_RST_CHAN7 && !logic_restart))
		else $error("channel 7 register not at reset value");
	drive_reset_a: assert property (@(posedge core_clk)
		disable iff (!arst_n)
		first_cycle |-> (pad_drive_strength == `SRDR_RST_DRIVE && reg_rdata == 8'h00))
		else $error("drive register not at reset value");
	full_restores_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		full_req_s |=> pulse_s ##1 (chan7_slot_route == `SRDR_RST_CHAN7
		&& pad_drive_strength == `SRDR_RST_DRIVE))
		else $error("full restart did not restore defaults");
	full_holds_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		regs_restart |=> (chan7_slot_route == `SRDR_RST_CHAN7
		&& pad_drive_strength == `SRDR_RST_DRIVE))
		else $error("defaults not held during full restart");
	full_wins_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(full_cmd && logic_cmd && !restart_busy) |=> regs_restart)
		else $error("full restart lost to logic restart");
	logic_keeps_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		logic_req_s |=> (logic_restart && $stable(chan7_slot_route)
		&& $stable(pad_drive_strength))) else $error("logic restart changed registers");
	logic_only_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		logic_req_s |=> (!regs_restart) [*4])
		else $error("logic restart restored registers");
	restart_ends_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(logic_restart) |-> ##4 !logic_restart)
		else $error("restart pulse wrong length");
	pulse_max_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		logic_restart |-> pulse_len < 3'(`SRDR_PULSE_CYC))
		else $error("restart pulse too long");
	pulse_full_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		$fell(logic_restart) |-> pulse_len == 3'(`SRDR_PULSE_CYC))
		else $error("restart pulse too short");

	// read path
	chan7_read_a: assert property (@(posedge core_clk)
		disable iff (!arst_n) (reg_read && reg_addr == `SRDR_OFF_CHAN7)
		|=> reg_rdata == $past({chan7_slot_select, 3'h0, chan7_output_enable}))
		else $error("channel 7 read data wrong");
	drive_read_a: assert property (@(posedge core_clk)
		disable iff (!arst_n) (reg_read && reg_addr == `SRDR_OFF_DRIVE) |=> reg_rdata == $past({2'h0,
		audio_out_pad_strength, mic_clock_b_pad_strength, mic_clock_a_pad_strength}))
		else $error("drive read data wrong");
	restart_reads_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(reg_read && reg_addr == `SRDR_OFF_RESTART) |=> reg_rdata == 8'h00)
		else $error("restart register read nonzero");
	unmapped_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(reg_read && reg_addr != `SRDR_OFF_CHAN7 && reg_addr != `SRDR_OFF_DRIVE)
		|=> reg_rdata == 8'h00) else $error("unmapped read nonzero");
	rdata_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!reg_read |=> $stable(reg_rdata))
		else $error("read data changed without a read");
endmodule : srdr_regs
`default_nettype wire

/* design/srdr_restart_seq.sv */
// restart sequencer: turns a restart command into a fixed-length reset pulse
// assumes commands are one-cycle pulses on core_clk
`include "srdr_consts.svh"
`default_nettype none
module srdr_restart_seq (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// commands
	input wire logic full_cmd,
	input wire logic logic_cmd,
	// status
	output logic regs_restart,
	output logic logic_restart,
	output logic busy
);
	localparam logic [3:0] PULSE_LAST = 4'(`SRDR_PULSE_CYC - 1);
	srdr_pkg::srdr_state_t state;
	logic [3:0] count;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= srdr_pkg::SRDR_RUN;
		end else begin
			case (state)
				srdr_pkg::SRDR_RUN: begin
					if (full_cmd) begin
						state <= srdr_pkg::SRDR_FULL;
					end else if (logic_cmd) begin
						state <= srdr_pkg::SRDR_LOGIC;
					end
				end
				srdr_pkg::SRDR_FULL, srdr_pkg::SRDR_LOGIC: begin
					if (count == PULSE_LAST) begin
						state <= srdr_pkg::SRDR_RUN;
					end
				end
				default: state <= srdr_pkg::SRDR_RUN;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 4'h0;
		end else if (state == srdr_pkg::SRDR_RUN) begin
			count <= 4'h0;
		end else begin
			count <= count + 4'h1;
		end
	end

	assign regs_restart = (state == srdr_pkg::SRDR_FULL);
	assign logic_restart = (state != srdr_pkg::SRDR_RUN);
	assign busy = logic_restart;
endmodule : srdr_restart_seq
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the slot/drive/restart register bank
// assumes srdr_regs, srdr_pkg and srdr_consts.svh are compiled alongside
`include "srdr_consts.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_write = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic [3:0] chan7_slot_select;
	logic chan7_output_enable;
	logic [1:0] audio_out_pad_strength;
	logic [1:0] mic_clock_b_pad_strength;
	logic [1:0] mic_clock_a_pad_strength;
	logic logic_restart;
	logic restart_busy;
	int fails = 0;
	int total_checks = 0;
	always #25 core_clk = ~core_clk;
	srdr_regs dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .chan7_slot_select(chan7_slot_select),
		.chan7_output_enable(chan7_output_enable),
		.audio_out_pad_strength(audio_out_pad_strength),
		.mic_clock_b_pad_strength(mic_clock_b_pad_strength),
		.mic_clock_a_pad_strength(mic_clock_a_pad_strength),
		.logic_restart(logic_restart), .restart_busy(restart_busy));
	wire srdr_pkg::srdr_byte_t chan7_out = {chan7_slot_select, 3'b000, chan7_output_enable};
	wire srdr_pkg::srdr_byte_t drive_out = {2'b00, audio_out_pad_strength,
		mic_clock_b_pad_strength, mic_clock_a_pad_strength};
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (fails == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string what, input srdr_pkg::srdr_byte_t seen, exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input srdr_pkg::srdr_byte_t a, d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input srdr_pkg::srdr_byte_t a, exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("reg_rdata", reg_rdata, exp);
	endtask : rd
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(`SRDR_OFF_CHAN7, 8'h71);
		chk("chan7 fields", chan7_out, 8'h71);
		rd(`SRDR_OFF_DRIVE, 8'h2A);
		chk("drive fields", drive_out, 8'h2A);
		rd(`SRDR_OFF_RESTART, 8'h00);
	endtask : t_reset
	task automatic t_slots();
		for (int s = 0; s < 16; s++) begin
			wr(`SRDR_OFF_CHAN7, {s[3:0], 4'hE});
			rd(`SRDR_OFF_CHAN7, {s[3:0], 4'h0});
			chk("chan7 fields", chan7_out, {s[3:0], 4'h0});
		end
		wr(`SRDR_OFF_CHAN7, 8'h5F);
		rd(`SRDR_OFF_CHAN7, 8'h51);
		chk("chan7 fields", chan7_out, 8'h51);
	endtask : t_slots
	task automatic t_drive();
		logic [1:0] a, b, c;
		for (int k = 0; k < 4; k++) begin
			a = k[1:0];
			b = a + 2'h1;
			c = a + 2'h2;
			wr(`SRDR_OFF_DRIVE, {2'b11, a, b, c});
			rd(`SRDR_OFF_DRIVE, {2'b00, a, b, c});
			chk("drive fields", drive_out, {2'b00, a, b, c});
		end
	endtask : t_drive
	task automatic t_unmapped();
		wr(8'h13, 8'hFF);
		rd(8'h13, 8'h00);
		wr(`SRDR_OFF_RESTART, 8'h00);
		rd(`SRDR_OFF_RESTART, 8'h00);
		chk("restart idle", {7'h00, logic_restart}, 8'h00);
		chk("chan7 kept", chan7_out, 8'h51);
	endtask : t_unmapped
	task automatic t_restart(input srdr_pkg::srdr_byte_t cmd, exp7, expd);
		int highs;
		highs = 0;
		wr(`SRDR_OFF_CHAN7, 8'h30);
		wr(`SRDR_OFF_DRIVE, 8'h1B);
		wr(`SRDR_OFF_RESTART, cmd);
		for (int i = 0; i < 20; i++) begin
			#1;
			if (logic_restart === 1'b1) begin
				highs++;
				chk("busy", {7'h00, restart_busy}, 8'h01);
				if (highs > 1) chk("chan7 in pulse", chan7_out, exp7);
				if (highs > 1) chk("drive in pulse", drive_out, expd);
			end
			@(posedge core_clk);
		end
		if (logic_restart !== 1'b0) begin
			fails++;
			final_report();
		end else begin
			chk("pulse cycles", highs[7:0], 8'h04);
			rd(`SRDR_OFF_CHAN7, exp7);
			rd(`SRDR_OFF_DRIVE, expd);
			rd(`SRDR_OFF_RESTART, 8'h00);
		end
	endtask : t_restart
	task automatic t_arst();
		wr(`SRDR_OFF_CHAN7, 8'hC0);
		wr(`SRDR_OFF_DRIVE, 8'h05);
		rd(`SRDR_OFF_DRIVE, 8'h05);
		@(posedge core_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		#1;
		chk("reset rdata", reg_rdata, 8'h00);
		chk("chan7 fields", chan7_out, 8'h71);
		chk("drive fields", drive_out, 8'h2A);
		chk("restart idle", {7'h00, logic_restart}, 8'h00);
		rd(`SRDR_OFF_CHAN7, 8'h71);
	endtask : t_arst
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset();
		t_slots();
		t_drive();
		t_unmapped();
		t_restart(8'h01, 8'h30, 8'h1B);
		t_restart(8'h02, 8'h71, 8'h2A);
		t_restart(8'h03, 8'h71, 8'h2A);
		t_arst();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
